/* rtl/prs_slave.sv */
// Slave end: paged register access over the two-wire bus.
//
// Notes on behaviour
// - Slave only; base address byte default B0.
// - Accepts every bus rate; never slows clock.
// - Clock idle past 35 ms resets interface.
// - Stuck data line freed within nine clocks.
// - Master code 00001xxx enters high speed.
// - No clock stretching; read data ready early.
// - Continuous high speed needs no master code.
// - Address zero is page control; LSB ignored.
// - Page write holds until next address byte; auto return clears it at STOP.
// - Master reads back page control after change.
// - Slave address bit one selects the page.
// - Bytes of eight bits, MSB first.
// - Acknowledge own address in ninth clock.
// - Write: address, register, data, all acknowledged.
// - Read: set pointer, restart, read, NACK, STOP.
// - Master ACK advances pointer, sends next.
// - Missing register reads as zero.
// - Master repeats same slave address after restart.
// - Further write bytes advance pointer, acknowledged.
// - Repeated write mode takes address data pairs.
// - START or STOP mid message drops it.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module prs_slave #(
  parameter int TIMEOUT_CYCLES = prs_pkg::PRS_TIMEOUT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  prs_bus_if.slave bus,
  input wire logic interface_enable_i,
  input wire logic [7:0] slave_base_address_i,
  input wire logic bus_idle_timeout_enable_i,
  input wire logic continuous_high_speed_enable_i,
  input wire logic repeated_write_enable_i,
  output logic [7:0] reg_addr_o,
  output logic [prs_pkg::PRS_PAGE_W-1:0] reg_page_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic hs_mode_o
);
  import prs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_REG,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } prs_state_t;

  prs_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic fetch_reg;
  logic capture_reg;
  logic sda_oe_reg;
  logic [PRS_PAGE_W-1:0] page_reg;
  logic return_reg;
  logic hs_reg;
  logic [31:0] tmo_reg;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic timeout_hit;
  logic abort;
  logic byte_done;
  logic addr_match;
  logic is_mcode;
  logic claim;
  logic [7:0] page_byte;

  prs_line_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .scl_o(scl),
    .sda_o(sda),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start),
    .stop_o(stop)
  );

  assign timeout_hit = bus_idle_timeout_enable_i && (tmo_reg == 32'(TIMEOUT_CYCLES));
  assign abort = stop || timeout_hit || !interface_enable_i;
  assign byte_done = (state_reg != ST_IDLE) && scl_fall && (bit_cnt_reg == PRS_ACK_SLOT) && !abort && !start;
  assign addr_match = shift_reg[7:PRS_SA_MATCH_LSB] == slave_base_address_i[7:PRS_SA_MATCH_LSB];
  assign is_mcode = (shift_reg & PRS_MCODE_MASK) == PRS_MCODE_VALUE;
  assign claim = (state_reg == ST_DEV) && addr_match && !is_mcode;
  assign page_byte = {return_reg, 1'b0, page_reg};

  // The ninth clock of each byte is the acknowledge slot.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || abort) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (start) begin
      state_reg <= ST_DEV;
      bit_cnt_reg <= 4'h0;
    end else if (state_reg != ST_IDLE && scl_rise) begin
      if (bit_cnt_reg == PRS_ACK_SLOT) begin
        bit_cnt_reg <= 4'h0;
        if (state_reg == ST_RDATA && sda) begin
          state_reg <= ST_SKIP;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (byte_done) begin
      case (state_reg)
        ST_DEV: begin
          if (claim) begin
            state_reg <= shift_reg[PRS_SA_RW_BIT] ? ST_RDATA : ST_REG;
          end else begin
            state_reg <= ST_SKIP;
          end
        end
        ST_REG: begin
          state_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          if (repeated_write_enable_i) begin
            state_reg <= ST_REG;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      shift_reg <= 8'h00;
    end else if (scl_rise && bit_cnt_reg != PRS_ACK_SLOT) begin
      shift_reg <= {shift_reg[6:0], sda};
    end
  end

  // Data changes after a falling clock edge; only reset, a START, a STOP, a timeout or disable can move the line while the clock is high.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || abort || start) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall && state_reg != ST_IDLE) begin
      if (bit_cnt_reg == PRS_ACK_SLOT) begin
        sda_oe_reg <= claim || state_reg == ST_REG || state_reg == ST_WDATA;
      end else begin
        sda_oe_reg <= (state_reg == ST_RDATA) && !tx_reg[3'(PRS_MSB_IDX - bit_cnt_reg)];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ptr_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      fetch_reg <= 1'b0;
      if (byte_done) begin
        case (state_reg)
          ST_DEV: begin
            if (claim && shift_reg[PRS_SA_RW_BIT]) begin
              addr_reg <= ptr_reg;
              fetch_reg <= 1'b1;
            end
          end
          ST_REG: begin
            ptr_reg <= shift_reg;
          end
          ST_WDATA: begin
            addr_reg <= ptr_reg;
            wdata_reg <= shift_reg;
            wr_reg <= 1'b1;
            if (!repeated_write_enable_i) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
          default: begin
          end
        endcase
      // In a read only the master's acknowledge advances the pointer; in the address slot the low line is our own.
      end else if (state_reg == ST_RDATA && scl_rise && bit_cnt_reg == PRS_ACK_SLOT && !sda && !sda_oe_reg
                   && !abort && !start) begin
        ptr_reg <= ptr_reg + 8'h01;
        addr_reg <= ptr_reg + 8'h01;
        fetch_reg <= 1'b1;
      end
    end
  end

  // Read data is loaded long before the falling edge that sends its first bit.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      capture_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else begin
      capture_reg <= fetch_reg;
      if (capture_reg) begin
        if (addr_reg == PRS_PAGE_CTRL_ADDR) begin
          tx_reg <= page_byte;
        end else begin
          tx_reg <= reg_rvalid_i ? reg_rdata_i : 8'h00;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      page_reg <= PRS_PAGE_RESET;
      return_reg <= 1'b0;
    end else if (stop && return_reg) begin
      page_reg <= PRS_PAGE_RESET;
      return_reg <= 1'b0;
    end else if (byte_done && claim) begin
      page_reg <= {{(PRS_PAGE_W-2){1'b0}}, shift_reg[PRS_SA_PAGE_BIT], 1'b0};
    end else if (wr_reg && addr_reg == PRS_PAGE_CTRL_ADDR) begin
      page_reg <= {wdata_reg[PRS_PAGE_W-1:1], 1'b0};
      return_reg <= wdata_reg[PRS_PAGE_RETURN_BIT];
    end
  end

  // High speed lasts until the end of the transfer that announced it.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || abort) begin
      hs_reg <= 1'b0;
    end else if (byte_done && state_reg == ST_DEV && is_mcode) begin
      hs_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || state_reg == ST_IDLE || scl_rise || scl_fall) begin
      tmo_reg <= 32'h0000_0000;
    end else if (tmo_reg != 32'(TIMEOUT_CYCLES)) begin
      tmo_reg <= tmo_reg + 32'h0000_0001;
    end
  end

  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe = sda_oe_reg;
  assign reg_addr_o = addr_reg;
  assign reg_page_o = page_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_wr_o = wr_reg && (addr_reg != PRS_PAGE_CTRL_ADDR);
  assign reg_rd_o = fetch_reg && (addr_reg != PRS_PAGE_CTRL_ADDR);
  assign hs_mode_o = hs_reg || continuous_high_speed_enable_i;
endmodule : prs_slave
`default_nettype wire

/* rtl/prs_pkg.sv */
// Shared constants and types for the paged register two-wire slave and its master.
package prs_pkg;
  localparam int PRS_CLK_HZ = 200_000_000;
  localparam int PRS_TIMEOUT_MS = 35;
  localparam int PRS_TIMEOUT_CYCLES = PRS_TIMEOUT_MS * (PRS_CLK_HZ / 1000);
  localparam logic [7:0] PRS_DEFAULT_BASE = 8'hB0;
  localparam int PRS_SA_RW_BIT = 0;
  localparam int PRS_SA_PAGE_BIT = 1;
  localparam int PRS_SA_MATCH_LSB = 2;
  localparam logic [7:0] PRS_MCODE_MASK = 8'hF8;
  localparam logic [7:0] PRS_MCODE_VALUE = 8'h08;
  localparam int PRS_PAGE_W = 6;
  localparam logic [7:0] PRS_PAGE_CTRL_ADDR = 8'h00;
  localparam int PRS_PAGE_RETURN_BIT = 7;
  localparam logic [PRS_PAGE_W-1:0] PRS_PAGE_RESET = 6'h00;
  localparam logic [3:0] PRS_MSB_IDX = 4'h7;
  localparam logic [3:0] PRS_ACK_SLOT = 4'h8;
  localparam logic [7:0] PRS_CMD_OFS = 8'h00;
  localparam logic [7:0] PRS_STAT_OFS = 8'h04;
  localparam logic [7:0] PRS_DIV_OFS = 8'h08;
  localparam int PRS_CMD_OP_LSB = 0;
  localparam int PRS_CMD_DATA_LSB = 8;
  localparam int PRS_CMD_NACK_BIT = 16;
  localparam int PRS_STAT_BUSY_BIT = 0;
  localparam int PRS_STAT_NACK_BIT = 1;
  localparam int PRS_STAT_RX_LSB = 8;
  localparam logic [15:0] PRS_DIV_RESET = 16'h00FA;
  typedef enum logic [2:0] {
    PRS_OP_NONE,
    PRS_OP_START,
    PRS_OP_STOP,
    PRS_OP_WRITE,
    PRS_OP_READ,
    PRS_OP_CLEAR
  } prs_op_t;
endpackage : prs_pkg

/* rtl/prs_bus_if.sv */
// Two-wire bus carrier joining the master end and the slave end.
`timescale 1ns/1ps
`default_nettype none
interface prs_bus_if;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wires: a line is low while any enabled driver pulls it low.
  assign scl = !(scl_m_oe && !scl_m_out);
  assign sda = !(sda_m_oe && !sda_m_out) && !(sda_s_oe && !sda_s_out);
  modport master (output scl_m_out, output scl_m_oe, output sda_m_out, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_out, output sda_s_oe, input scl, input sda);
endinterface : prs_bus_if
`default_nettype wire

/* rtl/prs_line_sync.sv */
// Synchroniser and condition detector for the two bus lines.
`timescale 1ns/1ps
`default_nettype none
module prs_line_sync (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  // Bit 1 carries the clock line, bit 0 the data line.
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] prev_reg;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      meta_reg <= {scl_i, sda_i};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign scl_o = sync_reg[1];
  assign sda_o = sync_reg[0];
  assign scl_rise_o = sync_reg[1] && !prev_reg[1];
  assign scl_fall_o = !sync_reg[1] && prev_reg[1];
  assign start_o = sync_reg[1] && prev_reg[1] && prev_reg[0] && !sync_reg[0];
  assign stop_o = sync_reg[1] && prev_reg[1] && !prev_reg[0] && sync_reg[0];
endmodule : prs_line_sync
`default_nettype wire

/* rtl/prs_master.sv */
// Master end: byte-level two-wire bus engine driven through a small register port.
`timescale 1ns/1ps
`default_nettype none
module prs_master (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  prs_bus_if.master bus,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [31:0] cpu_rdata_o
);
  import prs_pkg::*;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_START,
    MS_STOP,
    MS_BYTE
  } prs_mstate_t;

  prs_mstate_t mstate_reg;
  logic [2:0] ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic nack_reg;
  logic [7:0] rx_reg;
  logic ack_rx_reg;
  logic [15:0] div_reg;
  logic [15:0] tmr_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [31:0] rdata_reg;
  logic sda;
  logic tick;
  logic cmd_wr;
  logic bit_val;
  prs_op_t op;

  prs_line_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .scl_o(),
    .sda_o(sda),
    .scl_rise_o(),
    .scl_fall_o(),
    .start_o(),
    .stop_o()
  );

  assign tick = (tmr_reg == 16'h0000);
  assign cmd_wr = cpu_wr_i && (cpu_addr_i == PRS_CMD_OFS) && (mstate_reg == MS_IDLE);
  assign op = prs_op_t'(cpu_wdata_i[PRS_CMD_OP_LSB +: 3]);
  assign bit_val = (bit_reg == PRS_ACK_SLOT) ? nack_reg : tx_reg[3'(PRS_MSB_IDX - bit_reg)];

  // Each phase lasts one third of a period of the bus clock.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tmr_reg <= 16'h0000;
    end else if (mstate_reg == MS_IDLE || tick) begin
      tmr_reg <= div_reg - 16'h0001;
    end else begin
      tmr_reg <= tmr_reg - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mstate_reg <= MS_IDLE;
      ph_reg <= 3'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      nack_reg <= 1'b1;
      rx_reg <= 8'h00;
      ack_rx_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (cmd_wr) begin
      ph_reg <= 3'h0;
      bit_reg <= 4'h0;
      case (op)
        PRS_OP_START: begin
          mstate_reg <= MS_START;
        end
        PRS_OP_STOP: begin
          mstate_reg <= MS_STOP;
        end
        PRS_OP_WRITE: begin
          mstate_reg <= MS_BYTE;
          tx_reg <= cpu_wdata_i[PRS_CMD_DATA_LSB +: 8];
          nack_reg <= 1'b1;
        end
        PRS_OP_READ: begin
          mstate_reg <= MS_BYTE;
          tx_reg <= 8'hFF;
          nack_reg <= cpu_wdata_i[PRS_CMD_NACK_BIT];
        end
        PRS_OP_CLEAR: begin
          mstate_reg <= MS_BYTE;
          tx_reg <= 8'hFF;
          nack_reg <= 1'b1;
        end
        default: begin
        end
      endcase
    end else if (tick) begin
      case (mstate_reg)
        MS_START: begin
          ph_reg <= ph_reg + 3'h1;
          case (ph_reg)
            3'h0: sda_oe_reg <= 1'b0;
            3'h1: scl_oe_reg <= 1'b0;
            3'h2: sda_oe_reg <= 1'b1;
            3'h3: scl_oe_reg <= 1'b1;
            default: mstate_reg <= MS_IDLE;
          endcase
        end
        MS_STOP: begin
          ph_reg <= ph_reg + 3'h1;
          case (ph_reg)
            3'h0: sda_oe_reg <= 1'b1;
            3'h1: scl_oe_reg <= 1'b0;
            3'h2: sda_oe_reg <= 1'b0;
            default: mstate_reg <= MS_IDLE;
          endcase
        end
        MS_BYTE: begin
          case (ph_reg)
            3'h0: begin
              sda_oe_reg <= !bit_val;
              ph_reg <= 3'h1;
            end
            3'h1: begin
              scl_oe_reg <= 1'b0;
              ph_reg <= 3'h2;
            end
            default: begin
              scl_oe_reg <= 1'b1;
              ph_reg <= 3'h0;
              if (bit_reg == PRS_ACK_SLOT) begin
                ack_rx_reg <= sda;
                mstate_reg <= MS_IDLE;
              end else begin
                rx_reg <= {rx_reg[6:0], sda};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_reg <= PRS_DIV_RESET;
    end else if (cpu_wr_i && cpu_addr_i == PRS_DIV_OFS) begin
      div_reg <= cpu_wdata_i[15:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !cpu_rd_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (cpu_addr_i == PRS_STAT_OFS) begin
      rdata_reg <= 32'h0000_0000;
      rdata_reg[PRS_STAT_BUSY_BIT] <= (mstate_reg != MS_IDLE);
      rdata_reg[PRS_STAT_NACK_BIT] <= ack_rx_reg;
      rdata_reg[PRS_STAT_RX_LSB +: 8] <= rx_reg;
    end else if (cpu_addr_i == PRS_DIV_OFS) begin
      rdata_reg <= {16'h0000, div_reg};
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign bus.scl_m_out = 1'b0;
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe = sda_oe_reg;
  assign cpu_rdata_o = rdata_reg;
endmodule : prs_master
`default_nettype wire

/* tb/prs_monitor.sv */
// Concurrent checks on the two-wire link and the slave's register strobes.
`timescale 1ns/1ps
`default_nettype none
module prs_monitor (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda_s_oe,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o,
  input wire logic hs_mode_o,
  input wire logic continuous_high_speed_enable_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic scl_prev_reg;
  logic [3:0] hold_reg;
  always_ff @(posedge ref_clk_i) begin
    scl_prev_reg <= scl;
  end
  // Counts clock rises while the slave keeps the data line pulled low.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !sda_s_oe) begin
      hold_reg <= 4'h0;
    end else if (scl && !scl_prev_reg) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end
  property p_oe_moves_low;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_oe_moves_low: assert property (p_oe_moves_low) else $error("slave drive changed with clock high");
  property p_oe_steady_high;
    scl && $past(scl) |-> $stable(sda_s_oe);
  endproperty
  a_oe_steady_high: assert property (p_oe_steady_high) else $error("slave drive moved in high phase");
  property p_wr_single;
    reg_wr_o |=> !reg_wr_o [*8];
  endproperty
  a_wr_single: assert property (p_wr_single) else $error("write strobe too long");
  property p_rd_single;
    reg_rd_o |=> !reg_rd_o [*8];
  endproperty
  a_rd_single: assert property (p_rd_single) else $error("read strobe too long");
  property p_strobe_excl;
    reg_wr_o |-> !reg_rd_o;
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
  property p_wr_clock_low;
    reg_wr_o |-> !scl;
  endproperty
  a_wr_clock_low: assert property (p_wr_clock_low) else $error("write strobe outside low phase");
  property p_rd_settled;
    reg_rd_o |-> $stable(scl) [*3];
  endproperty
  a_rd_settled: assert property (p_rd_settled) else $error("read strobe too close to a clock edge");
  property p_hs_cont;
    continuous_high_speed_enable_i |-> hs_mode_o;
  endproperty
  a_hs_cont: assert property (p_hs_cont) else $error("continuous high speed not shown");
  property p_hold_bound;
    hold_reg <= 4'h9;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("data line held past nine clocks");
endmodule : prs_monitor
`default_nettype wire

/* tb/paged_register_i2c_slave_test.sv */
// Self-checking bench joining the master end and the slave end on one bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module paged_register_i2c_slave_test;
  import prs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cpu_addr = 8'h00;
  logic [31:0] cpu_wdata = 32'h0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [31:0] cpu_rdata;
  logic cont_en = 1'b0;
  logic rep_en = 1'b0;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] rdata = 8'h00;
  logic rvalid = 1'b0;
  logic [5:0] reg_page;
  logic reg_wr, reg_rd, hs;
  logic [7:0] mem [512];
  logic [21:0] exp_q [$];
  logic [31:0] st;
  logic [31:0] seed = 32'hA6B377B3;
  logic [7:0] d0, d1;
  int failures = 0;
  int n_tests = 0;
  prs_bus_if prs_bus_if_i ();
  prs_master prs_master_i (.ref_clk_i(clk), .reset_i(rst), .bus(prs_bus_if_i), .cpu_addr_i(cpu_addr),
    .cpu_wdata_i(cpu_wdata), .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd), .cpu_rdata_o(cpu_rdata));
  prs_slave #(.TIMEOUT_CYCLES(2000)) prs_slave_i (.ref_clk_i(clk), .reset_i(rst), .bus(prs_bus_if_i),
    .interface_enable_i(1'b1), .slave_base_address_i(PRS_DEFAULT_BASE), .bus_idle_timeout_enable_i(1'b1),
    .continuous_high_speed_enable_i(cont_en), .repeated_write_enable_i(rep_en), .reg_addr_o(reg_addr),
    .reg_page_o(reg_page), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .hs_mode_o(hs));
  prs_monitor prs_monitor_i (.ref_clk_i(clk), .reset_i(rst), .scl(prs_bus_if_i.scl),
    .sda_s_oe(prs_bus_if_i.sda_s_oe), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .hs_mode_o(hs),
    .continuous_high_speed_enable_i(cont_en));
  always #2.5 clk = ~clk;
  // Register file behind the slave; addresses with bit 7 set do not exist and offer junk data.
  always @(posedge clk) begin
    rvalid <= reg_rd && !reg_addr[7];
    rdata <= reg_addr[7] ? 8'hA5 : mem[{reg_page[1], reg_addr}];
    if (reg_wr) begin
      mem[{reg_page[1], reg_addr}] <= reg_wdata;
      `CHK({reg_page, reg_addr, reg_wdata}, exp_q.size() ? exp_q.pop_front() : 22'h3FFFFF)
    end
  end
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= w;
    cpu_rd <= !w;
    @(posedge clk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1 st = cpu_rdata;
  endtask : bus
  task automatic op(input prs_op_t o, input logic [7:0] b, input logic n);
    int i;
    bus(PRS_CMD_OFS, {15'h0, n, b, 5'h0, o}, 1'b1);
    for (i = 0; i < 4000; i++) begin
      bus(PRS_STAT_OFS, 32'h0, 1'b0);
      if (st[0] === 1'b0) break;
    end
    if (i == 4000) begin
      failures++;
      results();
    end
  endtask : op
  task automatic sb(input logic [7:0] b, input logic a);
    op(PRS_OP_WRITE, b, 1'b0);
    `CHK(st[1], a)
  endtask : sb
  task automatic s();
    op(PRS_OP_START, 8'h00, 1'b0);
  endtask : s
  task automatic p();
    op(PRS_OP_STOP, 8'h00, 1'b0);
  endtask : p
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(PRS_DIV_OFS, 32'h8, 1'b1);
    d0 = rnd();
    d1 = rnd();
    exp_q.push_back({6'h00, 8'h05, d0});
    exp_q.push_back({6'h00, 8'h06, d1});
    s(); sb(8'hB0, 0); sb(8'h05, 0); sb(d0, 0); sb(d1, 0); p();
    $display("test write done");
    s(); sb(8'hB0, 0); sb(8'h05, 0); s(); sb(8'hB1, 0);
    op(PRS_OP_READ, 8'h00, 1'b0);
    `CHK(st[15:8], d0)
    op(PRS_OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], d1)
    p();
    s(); sb(8'hB0, 0); sb(8'h90, 0); s(); sb(8'hB1, 0);
    op(PRS_OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], 8'h00)
    p();
    $display("test read done");
    s(); sb(8'hC4, 1); sb(8'h05, 1); p();
    d0 = rnd();
    exp_q.push_back({6'h02, 8'h07, d0});
    s(); sb(8'hB2, 0);
    `CHK(reg_page, 6'h02)
    sb(8'h07, 0); sb(d0, 0); p();
    s(); sb(8'hB2, 0); sb(8'h07, 0); s(); sb(8'hB3, 0);
    op(PRS_OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], d0)
    p();
    d0 = rnd();
    exp_q.push_back({6'h04, 8'h01, d0});
    s(); sb(8'hB0, 0); sb(8'h00, 0); sb(8'h05, 0); sb(d0, 0); p();
    `CHK(reg_page, 6'h04)
    s(); sb(8'hB0, 0); sb(8'h00, 0); sb(8'h86, 0);
    `CHK(reg_page, 6'h06)
    s(); sb(8'hB2, 0); sb(8'h00, 0); s(); sb(8'hB3, 0);
    op(PRS_OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], 8'h82)
    p();
    `CHK(reg_page, 6'h00)
    $display("test page done");
    @(posedge clk) rep_en <= 1'b1;
    d0 = rnd();
    d1 = rnd();
    exp_q.push_back({6'h00, 8'h10, d0});
    exp_q.push_back({6'h00, 8'h20, d1});
    s(); sb(8'hB0, 0); sb(8'h10, 0); sb(d0, 0); sb(8'h20, 0); sb(d1, 0); p();
    @(posedge clk) rep_en <= 1'b0;
    d0 = rnd();
    exp_q.push_back({6'h00, 8'h31, d0});
    s(); sb(8'hB0, 0); sb(8'h30, 0); s(); sb(8'hB0, 0); sb(8'h31, 0); sb(d0, 0); p();
    $display("test pairs done");
    s(); sb(8'h08 | (rnd() & 8'h07), 1);
    `CHK(hs, 1'b1)
    p();
    `CHK(hs, 1'b0)
    @(posedge clk) cont_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(hs, 1'b1)
    @(posedge clk) cont_en <= 1'b0;
    s(); sb(8'hB0, 0); sb(8'h90, 0); s(); sb(8'hB1, 0);
    op(PRS_OP_CLEAR, 8'h00, 1'b0);
    p();
    `CHK(prs_bus_if_i.sda, 1'b1)
    s(); sb(8'hB0, 0); sb(8'h40, 0);
    repeat (2100) @(posedge clk);
    sb(rnd(), 1);
    p();
    $display("test modes done");
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule : paged_register_i2c_slave_test
`default_nettype wire
